/* design/capture_compare_unit_params.svh */
// Register offsets, field positions, reset values and counts for the
// dual capture/compare block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef CAPTURE_COMPARE_UNIT_PARAMS_SVH
`define CAPTURE_COMPARE_UNIT_PARAMS_SVH

`define TMR_VAL_PAGE 8'h00
`define TMR_RLD_PAGE 8'h01
`define TMR_CFG_PAGE 8'h02
`define CH_VAL_PAGE 5'h02
`define CH_CFG_PAGE 5'h03
`define IRQ_STAT_ADDR 10'h080
`define IRQ_CLR_ADDR 10'h081
`define IRQ_EN_ADDR 10'h082

`define TCFG_SEL_LSB 0
`define TCFG_SRC_LSB 3
`define TCFG_RUN_BIT 5
`define CCFG_MODE_LSB 0
`define CCFG_TSEL_BIT 4

`define TMR_RESET 16'h0000
`define CH_RESET 16'h0000
`define TIMER_MAX 16'hffff
`define PRESCALE_BASE_LOG2 3

`endif

/* design/capture_compare_unit_pkg.sv */
// Types shared by the dual capture/compare block.
// Assumes capture_compare_unit_params.svh supplies the numeric constants.
package capture_compare_unit_pkg;

  typedef enum logic [1:0] {
    SRC_PRESCALED = 2'h0,
    SRC_GMT_OVF = 2'h1,
    SRC_EXT_COUNT = 2'h2
  } timer_src_t;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_CAP_RISE = 4'h1,
    MODE_CAP_FALL = 4'h2,
    MODE_CAP_BOTH = 4'h3,
    MODE_CMP0 = 4'h4,
    MODE_CMP1 = 4'h5,
    MODE_CMP2 = 4'h6,
    MODE_CMP3 = 4'h7,
    MODE_DOUBLE = 4'h8
  } chan_mode_t;

  typedef struct packed {
    logic run;
    logic [1:0] src;
    logic [2:0] timer_input_select;
  } timer_cfg_t;

  typedef struct packed {
    logic tsel;
    logic [3:0] mode;
  } chan_cfg_t;

  typedef struct packed {
    logic wr;
    logic [9:0] idx;
  } bus_req_t;

endpackage : capture_compare_unit_pkg

/* design/dual_capture_compare_unit.sv */
// Two capture/compare units of sixteen channels, four time-base timers,
// an AHB-Lite register slave and one level interrupt.
// Assumes pin and count inputs are synchronous to hclk.
`timescale 1ns/1ps
`include "capture_compare_unit_params.svh"

// Behaviour
// (RL1) Two units, sixteen channels each, thirty-two total.
// (RL2) Two 16-bit timers per unit with reload.
// (RL3) Timer clock: prescaled clock or external overflow.
// (RL4) First timer of each unit counts external events.
// (RL5) Each channel picks timer and capture/compare.
// (RL6) One pin per channel, input or output.
// (RL7) Capture copies assigned timer into channel register.
// (RL8) Capture raises the channel interrupt request.
// (RL9) Capture edge: rising, falling or both.
// (RL10) Compare channels match continuously against timer.
// (RL11) Mode 0: interrupt only, many per period.
// (RL12) Mode 1: pin toggles on each match.
// (RL13) Mode 2: interrupt only, one per period.
// (RL14) Mode 3: match sets pin, overflow clears.
// (RL15) Double mode: two registers toggle one pin.
// (RL16) Input select codes divide clock by 8..1024.
// (RL17) Reload zero gives full 16-bit period.
// (RL18) Timer counts ticks, reloads and pulses overflow.
// (RL19) Idle channel inert; mode applies next tick.
module dual_capture_compare_unit
  import capture_compare_unit_pkg::*;
#(
  parameter int CH_PER_UNIT = 16,
  parameter int PRESCALE_BITS = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] cc_pin_in,
  output logic [31:0] cc_pin_out,
  output logic [31:0] cc_pin_oe,
  input wire logic [1:0] ext_count_in,
  input wire logic gmt_overflow,
  output logic irq
);

  localparam int NCH = 2 * CH_PER_UNIT; // RL1

  initial begin
    if (CH_PER_UNIT != 16 || PRESCALE_BITS != 10) begin
      $error("Only sixteen channels per unit and a 10-bit prescaler.");
    end
  end

  // Bus slave: address phase capture and decode.
  bus_req_t req_reg;
  bus_req_t req_next;
  logic req_valid_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_data;
  wire addr_phase = hsel & hready & htrans[1];
  wire [9:0] a_idx = haddr[11:2];
  wire wr_now = req_valid_reg & req_reg.wr;
  wire [9:0] w_idx = req_reg.idx;
  wire wr_tval = wr_now & (w_idx[9:2] == `TMR_VAL_PAGE);
  wire wr_trld = wr_now & (w_idx[9:2] == `TMR_RLD_PAGE);
  wire wr_tcfg = wr_now & (w_idx[9:2] == `TMR_CFG_PAGE);
  wire wr_cval = wr_now & (w_idx[9:5] == `CH_VAL_PAGE);
  wire wr_ccfg = wr_now & (w_idx[9:5] == `CH_CFG_PAGE);
  wire wr_iclr = wr_now & (w_idx == `IRQ_CLR_ADDR);
  wire wr_ien = wr_now & (w_idx == `IRQ_EN_ADDR);

  assign req_next = '{wr: hwrite, idx: a_idx};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
      req_valid_reg <= 1'b0;
    end else begin
      req_valid_reg <= addr_phase;
      req_reg <= req_next;
    end
  end

  // Prescaler: a tick for divisor 2**(k+3) when the low bits are all ones.
  logic [PRESCALE_BITS-1:0] presc_reg;
  logic [7:0] presc_tick;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_presc
      assign presc_tick[k] =
        &presc_reg[k+`PRESCALE_BASE_LOG2-1:0]; // RL16
    end
  endgenerate

  // External count inputs: rising edge counts one.
  logic [1:0] ext_prev_reg;
  wire [1:0] ext_rise = ext_count_in & ~ext_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_reg <= 2'h0;
    end else begin
      ext_prev_reg <= ext_count_in;
    end
  end

  // Time-base timers: index 2u is the unit's primary, 2u+1 the secondary.
  logic [15:0] timer_reg [4];
  logic [15:0] reload_reg [4];
  timer_cfg_t tcfg_reg [4];
  logic [3:0] tick;
  logic [3:0] ovf;
  logic [3:0] upd_reg;
  logic [3:0] ovf_reg;

  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_timer
      logic src_pulse;
      logic [15:0] timer_next;
      assign src_pulse =
        (tcfg_reg[t].src == SRC_PRESCALED) ?
          presc_tick[tcfg_reg[t].timer_input_select] : // RL3
        (tcfg_reg[t].src == SRC_GMT_OVF) ? gmt_overflow : // RL3
        (tcfg_reg[t].src == SRC_EXT_COUNT && (t % 2) == 0) ?
          ext_rise[t/2] : 1'b0; // RL4
      assign tick[t] = tcfg_reg[t].run & src_pulse;
      assign ovf[t] = tick[t] & (timer_reg[t] == `TIMER_MAX); // RL18
      assign timer_next =
        (wr_tval && w_idx[1:0] == t) ? hwdata[15:0] :
        ovf[t] ? reload_reg[t] : // RL17
        tick[t] ? timer_reg[t] + 16'h0001 : timer_reg[t]; // RL18

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          timer_reg[t] <= `TMR_RESET;
          reload_reg[t] <= `TMR_RESET;
          tcfg_reg[t] <= '0;
          upd_reg[t] <= 1'b0;
          ovf_reg[t] <= 1'b0;
        end else begin
          timer_reg[t] <= timer_next; // RL2
          upd_reg[t] <= tick[t] | (wr_tval && w_idx[1:0] == t);
          ovf_reg[t] <= ovf[t]; // RL18
          if (wr_trld && w_idx[1:0] == t) begin
            reload_reg[t] <= hwdata[15:0]; // RL2
          end
          if (wr_tcfg && w_idx[1:0] == t) begin
            tcfg_reg[t] <= timer_cfg_t'(hwdata[5:0]);
          end
        end
      end
    end
  endgenerate

  // Channels.
  logic [15:0] ccv_reg [NCH];
  chan_cfg_t ccfg_reg [NCH];
  chan_cfg_t act_reg [NCH];
  logic [NCH-1:0] done_reg;
  logic [NCH-1:0] pin_prev_reg;
  logic [NCH-1:0] ch_ev;
  logic [NCH-1:0] ch_tog;
  logic [NCH-1:0] ch_dbl;
  logic [NCH-1:0] ch_set;
  logic [NCH-1:0] ch_clr;
  logic [NCH-1:0] ch_drv;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_chan
      localparam int UNIT = c / CH_PER_UNIT;
      logic [1:0] tidx;
      logic [1:0] cfg_tidx;
      logic [3:0] m;
      logic rise;
      logic fall;
      logic cap_ev;
      logic is_cmp;
      logic once;
      logic hit;
      logic fire;
      assign m = act_reg[c].mode;
      assign tidx = {UNIT[0], act_reg[c].tsel}; // RL5
      assign cfg_tidx = {UNIT[0], ccfg_reg[c].tsel};
      assign rise = cc_pin_in[c] & ~pin_prev_reg[c];
      assign fall = ~cc_pin_in[c] & pin_prev_reg[c];
      assign cap_ev = (m == MODE_CAP_RISE && rise) || // RL9
                      (m == MODE_CAP_FALL && fall) || // RL9
                      (m == MODE_CAP_BOTH && (rise | fall)); // RL9
      assign is_cmp = (m >= MODE_CMP0) && (m <= MODE_DOUBLE); // RL19
      assign once = (m == MODE_CMP2) || (m == MODE_CMP3);
      assign hit = is_cmp & upd_reg[tidx] &
                   (timer_reg[tidx] == ccv_reg[c]); // RL10
      assign fire = hit & (~once | ~done_reg[c]); // RL13 RL14
      assign ch_ev[c] = cap_ev | fire; // RL8 RL11 RL13
      assign ch_dbl[c] = (m == MODE_DOUBLE);
      assign ch_tog[c] = fire & ((m == MODE_CMP1) || ch_dbl[c]); // RL12 RL15
      assign ch_set[c] = fire & (m == MODE_CMP3); // RL14
      assign ch_clr[c] = ovf_reg[tidx] & (m == MODE_CMP3); // RL14
      assign ch_drv[c] = (m == MODE_CMP1) || (m == MODE_CMP3) ||
                         ch_dbl[c]; // RL6

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ccv_reg[c] <= `CH_RESET;
          ccfg_reg[c] <= '0;
          act_reg[c] <= '0;
          done_reg[c] <= 1'b0;
          pin_prev_reg[c] <= 1'b0;
        end else begin
          pin_prev_reg[c] <= cc_pin_in[c];
          if (cap_ev) begin
            ccv_reg[c] <= timer_reg[tidx]; // RL7
          end else if (wr_cval && w_idx[4:0] == c) begin
            ccv_reg[c] <= hwdata[15:0];
          end
          if (wr_ccfg && w_idx[4:0] == c) begin
            ccfg_reg[c] <= chan_cfg_t'(hwdata[4:0]); // RL5
          end
          if (tick[cfg_tidx]) begin
            act_reg[c] <= ccfg_reg[c]; // RL19
          end
          done_reg[c] <= (fire & once) |
                         (done_reg[c] & ~ovf_reg[tidx]); // RL13 RL14
        end
      end
    end
  endgenerate

  // Pins: a low-half pin also obeys its double-register partner.
  logic [NCH-1:0] pin_reg;
  logic [NCH-1:0] oe_reg;
  logic [NCH-1:0] pin_tog;
  logic [NCH-1:0] pin_drv;

  genvar p;
  generate
    for (p = 0; p < NCH; p++) begin : g_pin
      if ((p % CH_PER_UNIT) < CH_PER_UNIT / 2) begin : g_lo
        assign pin_tog[p] = (ch_tog[p] & ~ch_dbl[p]) |
          ((ch_tog[p] & ch_dbl[p]) ^
           (ch_tog[p+8] & ch_dbl[p+8])); // RL15
        assign pin_drv[p] = ch_drv[p] | ch_dbl[p+8]; // RL15
      end else begin : g_hi
        assign pin_tog[p] = ch_tog[p] & ~ch_dbl[p];
        assign pin_drv[p] = ch_drv[p] & ~ch_dbl[p];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_reg[p] <= 1'b0;
          oe_reg[p] <= 1'b0;
        end else begin
          oe_reg[p] <= pin_drv[p]; // RL6
          if (ch_set[p]) begin
            pin_reg[p] <= 1'b1; // RL14
          end else if (ch_clr[p]) begin
            pin_reg[p] <= 1'b0; // RL14
          end else if (pin_tog[p]) begin
            pin_reg[p] <= ~pin_reg[p]; // RL12
          end
        end
      end
    end
  endgenerate

  // Interrupts: a new event wins over a clear in the same cycle.
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] en_reg;
  logic irq_reg;
  wire [31:0] clr_mask = wr_iclr ? hwdata : 32'h0000_0000;
  assign stat_next = ch_ev | (stat_reg & ~clr_mask); // RL8

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= 32'h0000_0000;
      en_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_ien) begin
        en_reg <= hwdata;
      end
      irq_reg <= |(stat_next & en_reg);
    end
  end

  // Read data is picked during the address phase.
  wire rd_tval = (a_idx[9:2] == `TMR_VAL_PAGE);
  wire rd_trld = (a_idx[9:2] == `TMR_RLD_PAGE);
  wire rd_tcfg = (a_idx[9:2] == `TMR_CFG_PAGE);
  wire rd_cval = (a_idx[9:5] == `CH_VAL_PAGE);
  wire rd_ccfg = (a_idx[9:5] == `CH_CFG_PAGE);
  assign rd_data =
    rd_tval ? {16'h0000, timer_reg[a_idx[1:0]]} :
    rd_trld ? {16'h0000, reload_reg[a_idx[1:0]]} :
    rd_tcfg ? {26'h0000000, tcfg_reg[a_idx[1:0]]} :
    rd_cval ? {16'h0000, ccv_reg[a_idx[4:0]]} :
    rd_ccfg ? {27'h0000000, ccfg_reg[a_idx[4:0]]} :
    (a_idx == `IRQ_STAT_ADDR) ? stat_reg :
    (a_idx == `IRQ_EN_ADDR) ? en_reg : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= rd_data;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign cc_pin_out = pin_reg;
  assign cc_pin_oe = oe_reg;
  assign irq = irq_reg;

endmodule : dual_capture_compare_unit

/* verification/cc_pin_model.sv */
// Behavioural model of the channel pins outside the block.
// Assumes the bench sets the level of every pin the block does not drive.
`timescale 1ns/1ps
module cc_pin_model (
  input wire logic [31:0] lvl,
  input wire logic [31:0] drv,
  input wire logic [31:0] oe,
  output logic [31:0] pin
);
  // A driven pin reads back its own level.
  assign pin = (oe & drv) | (~oe & lvl);
endmodule : cc_pin_model

/* verification/dual_capture_compare_unit_props.sv */
// Port checker for the dual capture/compare block.
// Assumes hready is the block's own hreadyout looped back.
`timescale 1ns/1ps
module dual_capture_compare_unit_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [31:0] cc_pin_out,
  input wire logic [31:0] cc_pin_oe,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans[1];
  wire rd = tk && !hwrite;
  wire [11:0] a = haddr[11:0];
  wire wc = tk && hwrite && (a == 12'h204 || a == 12'h208);
  logic en_ph;
  logic cfg_seen;
  logic [31:0] en_sh;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ph <= 1'b0;
      cfg_seen <= 1'b0;
      en_sh <= 32'h0;
    end else begin
      en_ph <= tk && hwrite && a == 12'h208;
      cfg_seen <= cfg_seen || (tk && hwrite && a[11:7] == 5'h03);
      if (en_ph) begin
        en_sh <= hwdata;
      end
    end
  end
  property p_irq_fall;
    $fell(irq) |-> $past(wc, 2) || $past(wc, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell with no clear");
  property p_irq_mask;
    (en_sh == 32'h0 && $past(en_sh) == 32'h0) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with all masked");
  property p_oe_cause;
    !cfg_seen |-> $stable(cc_pin_oe);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin enable without config");
  property p_pin_idle;
    ((cc_pin_out ^ $past(cc_pin_out)) & ~cc_pin_oe & ~$past(cc_pin_oe))
      == 32'h0;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("undriven pin moved");
  property p_tmr_width;
    rd && a < 12'h010 |=> hrdata[31:16] == 16'h0;
  endproperty
  a_tmr_width: assert property (p_tmr_width)
    else $error("timer wider than 16 bits");
  property p_chan_width;
    rd && a[11:7] == 5'h02 |=> hrdata[31:16] == 16'h0;
  endproperty
  a_chan_width: assert property (p_chan_width)
    else $error("channel wider than 16 bits");
  property p_tcfg_width;
    rd && a[11:4] == 8'h02 |=> hrdata[31:6] == 26'h0;
  endproperty
  a_tcfg_width: assert property (p_tcfg_width)
    else $error("timer config stray bits");
  property p_ccfg_width;
    rd && a[11:7] == 5'h03 |=> hrdata[31:5] == 27'h0;
  endproperty
  a_ccfg_width: assert property (p_ccfg_width)
    else $error("channel config stray bits");
  cover property ($rose(irq));
  cover property ($rose(cc_pin_oe[8]));
  cover property ($fell(cc_pin_out[9]));
endmodule : dual_capture_compare_unit_props

bind dual_capture_compare_unit dual_capture_compare_unit_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
  .irq(irq)
);

/* verification/tb.sv */
// Self-checking bench for the dual capture/compare block.
// Assumes zero-wait bus answers and the pin model on the channel pins.
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] lvl = 32'h0;
  logic [1:0] ext = 2'h0;
  logic gmt = 1'b0;
  logic hrdy, hresp, irq, hit;
  logic [31:0] hrdata, pout, poe, pin, d, t;
  int ch[6] = '{4, 8, 9, 10, 11, 12};
  int md[6] = '{8, 5, 7, 4, 6, 8};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  dual_capture_compare_unit u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .cc_pin_in(pin), .cc_pin_out(pout), .cc_pin_oe(poe),
    .ext_count_in(ext), .gmt_overflow(gmt), .irq(irq));
  cc_pin_model u_pins (.lvl(lvl), .drv(pout), .oe(poe), .pin(pin));
  initial forever #5 hclk = ~hclk;
  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input int a, input logic w, input logic [31:0] wd,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input int a, input logic [31:0] v);
    xfer(a, 1'b1, v, d);
    @(posedge hclk);
  endtask : wr
  task automatic rd(input int a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, d);
    chk(d, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      gmt <= 1'b1;
      @(posedge hclk);
      gmt <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask : tick
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h000, 32'h0);
    rd(12'h200, 32'h0);
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(12'h020, 32'h20 | c);
      repeat (8 << c) @(posedge hclk);
      xfer(12'h000, 1'b0, 32'h0, t);
      repeat ((32 << c) - 2) @(posedge hclk);
      rd(12'h000, t + 32'h4);
    end
    for (int u = 0; u < 2; u++) begin
      wr(12'h020 + 8 * u, 32'h30);
      wr(8 * u, 32'h10);
      repeat (3) begin
        ext <= 2'(1 << u);
        repeat (2) @(posedge hclk);
        ext <= 2'h0;
        repeat (2) @(posedge hclk);
      end
      rd(8 * u, 32'h13);
    end
    wr(12'h024, 32'h28);
    wr(12'h014, 32'h1234);
    wr(12'h004, 32'hfffe);
    tick(3);
    rd(12'h004, 32'h1235);
    wr(12'h014, 32'h0);
    wr(12'h004, 32'hffff);
    tick(1);
    rd(12'h004, 32'h0);
    wr(12'h208, 32'hffff_ffff);
    rd(12'h208, 32'hffff_ffff);
    for (int m = 1; m < 4; m++) begin
      wr(12'h180 + 4 * m, 32'h10 | m);
      tick(1);
      xfer(12'h004, 1'b0, 32'h0, t);
      for (int e = 0; e < 2; e++) begin
        hit = (m == 3 || m == e + 1);
        wr(12'h204, 32'hffff_ffff);
        wr(12'h100 + 4 * m, 32'h0);
        lvl <= lvl ^ (32'h1 << m);
        repeat (4) @(posedge hclk);
        rd(12'h100 + 4 * m, hit ? t : 32'h0);
        rd(12'h200, {31'h0, hit} << m);
        chk({31'h0, irq}, {31'h0, hit});
      end
    end
    wr(12'h004, 32'h100);
    for (int i = 0; i < 6; i++) begin
      wr(12'h100 + 4 * ch[i], (i == 5) ? 32'h103 : 32'h102);
      wr(12'h180 + 4 * ch[i], 32'h10 | md[i]);
    end
    wr(12'h204, 32'hffff_ffff);
    tick(2);
    chk({23'h0, pout[12:4]}, 32'h031);
    chk({23'h0, poe[12:4]}, 32'h031);
    rd(12'h200, 32'h0f10);
    wr(12'h204, 32'hffff_ffff);
    wr(12'h004, 32'h101);
    tick(1);
    rd(12'h200, 32'h0510);
    chk({23'h0, pout[12:4]}, 32'h020);
    tick(1);
    chk({23'h0, pout[12:4]}, 32'h021);
    wr(12'h004, 32'hffff);
    tick(1);
    chk({23'h0, pout[12:4]}, 32'h001);
    wr(12'h208, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    print_verdict();
  end
endmodule : tb
